// *** design/card_ctl_card.sv ***
/*
  Card end: reset handling, write strobe capture, shared output pins.
  Also holds pin_sync, the pin filter that both ends use.
  Assumes host pins are asynchronous to mclk_i; the mode comes from the
  surrounding card logic on mclk_i.
*/
`timescale 1ns/10ps
module card_ctl_card
  import card_ctl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input card_mode_t mode_i,
  input wire logic port_is_16_i,
  input wire logic word_cycle_i,
  input wire logic stretch_req_i,
  output logic [7:0] data_reg_o,
  output logic [7:0] cfg_reg_o,
  output logic data_wr_o,
  output logic cfg_wr_o,
  output logic card_reset_o,
  card_ctl_if.card bus
);

  card_mode_t last_mode;
  logic rst_seen;
  logic we_seen_n;
  logic we_prev_n;
  logic armed;
  logic init_busy;
  logic [INIT_CNT_W-1:0] init_cnt;
  logic [2:0] stretch_cnt;

  wire is_ata = (mode_i == direct_ata_mode);
  wire is_mem = (mode_i == card_memory_mode);
  wire is_io = (mode_i == card_io_mode);
  // Reset request level depends on the mode
  wire rst_req = is_ata ? !rst_seen : rst_seen;
  // A mode change into or out of ATA flips the reset pin's polarity; the stale filtered
  // level must not be taken as a reset request in that cycle
  wire mode_moved = (mode_i != last_mode);
  // A reset held since power-up is ignored until first released
  wire hw_reset = rst_req && armed && !mode_moved;
  wire soft_reset = cfg_reg_o[SOFT_RESET_BIT];
  wire any_reset = hw_reset || soft_reset;
  wire we_rise = !we_prev_n && we_seen_n && !is_ata;
  wire take_data = we_rise && is_mem && !bus.cfg_space;
  wire take_cfg = we_rise && bus.cfg_space && (is_mem || is_io);
  wire stretching = (stretch_cnt != 3'h0) || stretch_req_i;

  // Pin function picked from the active mode
  assign bus.stretch_n = !stretching;
  assign bus.wp_n = is_mem ? init_busy :
                    is_io ? !port_is_16_i :
                    !word_cycle_i;
  assign bus.voltage_sense_primary_n = 1'b0;
  assign bus.voltage_sense_secondary_n_o = 1'b0;
  assign bus.voltage_sense_secondary_n_oe = 1'b0;
  assign bus.ready = !init_busy;
  assign card_reset_o = init_busy;

  // Host reset and write strobe pins cross into mclk_i through the shared filter
  pin_sync #(.IDLE(1'b0)) i_pin_sync_rst (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .pin_i(bus.reset_pin),
    .level_o(rst_seen)
  );

  pin_sync #(.IDLE(1'b1)) i_pin_sync_we (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .pin_i(bus.write_strobe_n),
    .level_o(we_seen_n)
  );

  // Previous filtered strobe level, for edge detection
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      we_prev_n <= 1'b1;
    end else begin
      we_prev_n <= we_seen_n;
    end
  end

  // Mode of the previous cycle; a change disarms the hardware reset
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_mode <= card_memory_mode;
    end else begin
      last_mode <= mode_i;
    end
  end

  // Arm the hardware reset only after the pin has been seen inactive,
  // so a pin left floating or high cannot hold the card forever
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed <= 1'b0;
    end else if (mode_moved) begin
      // Wait for the pin to be seen inactive under the new polarity
      armed <= 1'b0;
    end else if (!init_busy && !rst_req) begin
      armed <= 1'b1;
    end
  end

  // Initialisation timer; restarted by any reset, runs once at power-up
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      init_busy <= 1'b1;
      init_cnt <= INIT_CNT_W'(INIT_CYCLES);
    end else if (any_reset) begin
      init_busy <= 1'b1;
      init_cnt <= INIT_CNT_W'(INIT_CYCLES);
    end else if (init_cnt != '0) begin
      init_cnt <= init_cnt - 1'b1;
    end else begin
      init_busy <= 1'b0;
    end
  end

  // Register writes; soft reset clears the configuration register too
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_reg_o <= DATA_RESET;
      cfg_reg_o <= DATA_RESET;
      data_wr_o <= 1'b0;
      cfg_wr_o <= 1'b0;
    end else begin
      data_wr_o <= take_data && !init_busy;
      cfg_wr_o <= take_cfg && !init_busy;
      if (any_reset) begin
        data_reg_o <= DATA_RESET;
        cfg_reg_o <= DATA_RESET;
      end else if (!init_busy) begin
        if (take_data) begin
          data_reg_o <= bus.data;
        end
        if (take_cfg) begin
          cfg_reg_o <= bus.data;
        end
      end
    end
  end

  // Stretch every strobe falling edge outside ATA mode for a fixed count; stretch_req_i
  // lets the card logic hold the host off for longer when it must
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stretch_cnt <= 3'h0;
    end else if (we_prev_n && !we_seen_n && !is_ata) begin
      stretch_cnt <= 3'(STRETCH_CYCLES);
    end else if (stretch_cnt != 3'h0) begin
      stretch_cnt <= stretch_cnt - 3'h1;
    end
  end

endmodule // card_ctl_card

// Three-flop pin filter shared by both ends. A new level is taken only
// when the second and third stages agree, so a pulse of one clock never
// passes; the price is one more cycle of latency than a bare synchroniser
module pin_sync
  import card_ctl_pkg::*;
#(
  parameter logic IDLE = 1'b0
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic pin_i,
  output logic level_o
);

  logic [2:0] stages;

  // Only the second and third flops are read outside the chain
  wire agree = (stages[1] == stages[2]);

  // Reset to the pin's idle level so no false edge follows reset
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stages <= {3{IDLE}};
      level_o <= IDLE;
    end else begin
      stages <= {stages[1:0], pin_i};
      if (agree) begin
        level_o <= stages[2];
      end
    end
  end

endmodule // pin_sync

// *** design/card_ctl_host.sv ***
/*
  Host end: drives reset and write strobes toward the card.
  Assumes a user issues one write at a time and waits for done_o.
*/
`timescale 1ns/10ps
module card_ctl_host
  import card_ctl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input card_mode_t mode_i,
  input wire logic hw_reset_i,
  input wire logic wr_req_i,
  input wire logic wr_cfg_i,
  input wire logic [7:0] wr_data_i,
  output logic busy_o,
  output logic done_o,
  output logic card_ready_o,
  card_ctl_if.host bus
);

  typedef enum logic [2:0] {
    h_idle, h_reset, h_setup, h_low, h_hold
  } host_state_t;

  host_state_t state;
  logic [7:0] cnt;
  logic [7:0] data;
  logic cfg;
  logic stretch_seen_n;
  logic ready_seen;

  wire is_ata = (mode_i == direct_ata_mode);
  // ATA reset is active low; card modes active high
  wire reset_level = (state == h_reset) ^ is_ata;
  // ATA hosts keep the strobe tied high
  wire strobe_low = (state == h_low) && !is_ata;

  assign bus.reset_pin = reset_level;
  assign bus.write_strobe_n = !strobe_low;
  assign bus.cfg_space = cfg;
  assign bus.data = data;
  assign busy_o = (state != h_idle);
  assign card_ready_o = ready_seen;

  // Card stretch and ready outputs cross into mclk_i through the shared three-flop filter
  pin_sync #(.IDLE(1'b1)) i_pin_sync_stretch (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .pin_i(bus.stretch_n),
    .level_o(stretch_seen_n)
  );

  pin_sync #(.IDLE(1'b0)) i_pin_sync_ready (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .pin_i(bus.ready),
    .level_o(ready_seen)
  );

  // Write sequencer; holds the strobe low while the card stretches
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= h_idle;
      cnt <= 8'h00;
      data <= DATA_RESET;
      cfg <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state)
        h_idle: begin
          if (hw_reset_i) begin
            state <= h_reset;
            cnt <= 8'(HRESET_CYCLES);
          end else if (wr_req_i && ready_seen) begin
            data <= wr_data_i;
            cfg <= wr_cfg_i;
            state <= h_setup;
          end
        end
        h_reset: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h01) begin
            state <= h_idle;
          end
        end
        h_setup: begin
          state <= h_low;
          cnt <= 8'(STROBE_LOW_CYCLES);
        end
        h_low: begin
          if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end else if (stretch_seen_n) begin
            state <= h_hold;
          end
        end
        h_hold: begin
          state <= h_idle;
          done_o <= 1'b1;
        end
        default: state <= h_idle;
      endcase
    end
  end

endmodule // card_ctl_host

// *** design/card_ctl_if.sv ***
/*
  Control-pin carrier between the host end and the card end.
  Assumes the testbench resolves floating or tied pins itself.
*/
`timescale 1ns/10ps
interface card_ctl_if;
  import card_ctl_pkg::*;

  logic reset_pin;         // High = reset (card modes), low = reset (ATA)
  logic write_strobe_n;    // Host write strobe
  logic cfg_space;         // High: write targets configuration registers
  logic [7:0] data;        // Host write data
  logic stretch_n;         // Cycle stretch / IORDY, low = wait
  logic wp_n;              // Write protect / port width / word select
  logic voltage_sense_primary_n;
  logic voltage_sense_secondary_n_o;
  logic voltage_sense_secondary_n_oe;
  logic ready;             // High = card ready

  modport card (
    input reset_pin, write_strobe_n, cfg_space, data,
    output stretch_n, wp_n, voltage_sense_primary_n,
    output voltage_sense_secondary_n_o, voltage_sense_secondary_n_oe,
    output ready
  );

  modport host (
    output reset_pin, write_strobe_n, cfg_space, data,
    input stretch_n, wp_n, voltage_sense_primary_n, ready
  );
endinterface

// *** design/card_ctl_pkg.sv ***
/*
  Shared constants and types for the card control-pin ends.
  Assumes one 200 MHz clock on each end and an interface file that joins them.
*/
package card_ctl_pkg;

  // Interface modes of the card
  typedef enum logic [1:0] {
    card_memory_mode,
    card_io_mode,
    direct_ata_mode
  } card_mode_t;

  localparam int unsigned CLK_MHZ = 200;

  // Power-up / reset initialisation time
  localparam int unsigned INIT_TIME_NS = 1000;
  localparam int unsigned INIT_CYCLES = (INIT_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned INIT_CNT_W = 16;

  // Least strobe low time the host gives, and its cycle count
  localparam int unsigned STROBE_TIME_NS = 40;
  localparam int unsigned STROBE_CYCLES =
    (STROBE_TIME_NS * CLK_MHZ + 999) / 1000;

  // Host reset pulse width
  localparam int unsigned HRESET_TIME_NS = 100;
  localparam int unsigned HRESET_CYCLES =
    (HRESET_TIME_NS * CLK_MHZ + 999) / 1000;

  // Cycles the card stretches each accepted write
  localparam int unsigned STRETCH_CYCLES = 4;

  // Cycles before a card stretch can reach the host: card filter, edge
  // detect and host filter in turn. A shorter strobe would end the cycle
  // before the host could ever see the card ask for a wait.
  localparam int unsigned WAIT_SETTLE_CYCLES = 10;
  localparam int unsigned STROBE_LOW_CYCLES =
    (STROBE_CYCLES > WAIT_SETTLE_CYCLES) ? STROBE_CYCLES : WAIT_SETTLE_CYCLES;

  // Soft reset bit position in the configuration option register
  localparam int unsigned SOFT_RESET_BIT = 7;

  localparam logic [7:0] DATA_RESET = 8'h00;

endpackage

// *** sim/card_ctl_chk.sv ***
/*
  Assertions on the control pins between host end and card end.
  Assumes one clock; instantiated beside the card_ctl_if instance.
*/
`timescale 1ns/10ps
module card_ctl_chk
  import card_ctl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input card_mode_t mode_i,
  input wire logic reset_pin,
  input wire logic write_strobe_n,
  input wire logic stretch_n,
  input wire logic wp_n,
  input wire logic ready
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  localparam int MIN_BUSY = INIT_CYCLES - 2;
  logic [15:0] busy_cnt;
  wire logic card_side = (mode_i != direct_ata_mode);
  // Busy length, so a ready that comes early is caught
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) busy_cnt <= 16'h0;
    else if (ready) busy_cnt <= 16'h0;
    else busy_cnt <= busy_cnt + 16'h1;
  end
  // Strobe fall, then stretch within the sync delay
  sequence s_fall; $fell(write_strobe_n) && ready && card_side; endsequence
  sequence s_low; !stretch_n; endsequence
  property p_stretch; s_fall |-> ##[1:10] s_low; endproperty
  a_stretch: assert property (p_stretch) else $error("no stretch");
  property p_strobe_w; $fell(write_strobe_n) |-> !write_strobe_n[*8];
  endproperty
  a_strobe_w: assert property (p_strobe_w) else $error("short strobe");
  property p_rdy_init; $rose(ready) |-> busy_cnt >= MIN_BUSY; endproperty
  a_rdy_init: assert property (p_rdy_init) else $error("early ready");
  property p_no_access; !ready |-> write_strobe_n; endproperty
  a_no_access: assert property (p_no_access) else $error("busy write");
  property p_wp_mem;
    mode_i == card_memory_mode && $past(mode_i, 2) == card_memory_mode
      && ready |-> !wp_n;
  endproperty
  a_wp_mem: assert property (p_wp_mem) else $error("wp high");
  property p_rst_card;
    $rose(reset_pin) && !$past(reset_pin, 2) && ready && card_side
      |-> ##[1:10] !ready;
  endproperty
  a_rst_card: assert property (p_rst_card) else $error("no reset");
  property p_rst_ata;
    $fell(reset_pin) && $past(reset_pin, 2) && ready && !card_side
      |-> ##[1:10] !ready;
  endproperty
  a_rst_ata: assert property (p_rst_ata) else $error("no ata reset");
  property p_ata_we; !card_side |-> write_strobe_n; endproperty
  a_ata_we: assert property (p_ata_we) else $error("ata strobe");
  // Host keeps the strobe low while the card stretches the cycle
  sequence s_wait_fall;
    $fell(stretch_n) && !write_strobe_n && card_side;
  endsequence
  property p_host_wait; s_wait_fall |-> !write_strobe_n[*8]; endproperty
  a_host_wait: assert property (p_host_wait) else $error("no wait");
endmodule // card_ctl_chk

// *** sim/tb_card_host_control_pins.sv ***
/*
  Testbench joining host end and card end over card_ctl_if.
  Assumes the design package and interface are compiled first.
*/
`timescale 1ns/10ps
module tb_card_host_control_pins
  import card_ctl_pkg::*;
;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  card_mode_t mode = card_memory_mode;
  logic hw_reset = 1'b0, wr_req = 1'b0, wr_cfg = 1'b0;
  logic port16 = 1'b0, word = 1'b0, str_req = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic busy, done, cready, creset;
  logic [7:0] dreg, creg;
  int mismatches = 0;
  int checks_done = 0;
  card_ctl_if link();
  card_ctl_host i_card_ctl_host (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .mode_i(mode), .hw_reset_i(hw_reset), .wr_req_i(wr_req),
    .wr_cfg_i(wr_cfg), .wr_data_i(wr_data), .busy_o(busy), .done_o(done),
    .card_ready_o(cready), .bus(link));
  card_ctl_card i_card_ctl_card (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .mode_i(mode), .port_is_16_i(port16), .word_cycle_i(word),
    .stretch_req_i(str_req), .data_reg_o(dreg), .cfg_reg_o(creg),
    .data_wr_o(), .cfg_wr_o(), .card_reset_o(creset), .bus(link));
  card_ctl_chk i_card_ctl_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .mode_i(mode), .reset_pin(link.reset_pin),
    .write_strobe_n(link.write_strobe_n), .stretch_n(link.stretch_n),
    .wp_n(link.wp_n), .ready(link.ready));
  // 200 MHz clock
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // Waits are bounded; running out ends the run as a failure
  task automatic wait_ready();
    int i;
    for (i = 0; i < 2000 && cready !== 1'b1; i++) tick(1);
    if (cready !== 1'b1) begin
      cmp(8'h0, 8'h1);
      finish_test();
    end
  endtask
  // One write, then room for the card's synchroniser to catch up
  task automatic wr(input logic cfg, input logic [7:0] d);
    int i;
    wr_req <= 1'b1;
    wr_cfg <= cfg;
    wr_data <= d;
    tick(1);
    wr_req <= 1'b0;
    for (i = 0; i < 500 && done !== 1'b1; i++) tick(1);
    if (done !== 1'b1) begin
      cmp(8'h0, 8'h1);
      finish_test();
    end
    tick(8);
  endtask
  task automatic pulse_reset();
    hw_reset <= 1'b1;
    tick(1);
    hw_reset <= 1'b0;
    tick(10);
  endtask
  // Memory, then I/O, then ATA mode, then resets in memory mode
  initial begin
    tick(8);
    reset_n_i <= 1'b1;
    wait_ready();
    wr(1'b0, 8'h5a);
    cmp(dreg, 8'h5a);
    wr(1'b1, 8'h21);
    cmp(creg, 8'h21);
    cmp(8'(link.wp_n), 8'h0);
    cmp(8'(link.voltage_sense_primary_n), 8'h0);
    cmp(8'(link.voltage_sense_secondary_n_oe), 8'h0);
    mode <= card_io_mode;
    tick(30);
    wait_ready();
    wr(1'b0, 8'h33);
    cmp(dreg, 8'h5a);
    wr(1'b1, 8'h42);
    cmp(creg, 8'h42);
    for (int v = 0; v < 2; v++) begin
      port16 <= v[0];
      tick(6);
      cmp(8'(link.wp_n), 8'(!v[0]));
    end
    mode <= direct_ata_mode;
    tick(30);
    wait_ready();
    for (int v = 0; v < 2; v++) begin
      word <= v[0];
      tick(6);
      cmp(8'(link.wp_n), 8'(!v[0]));
      str_req <= v[0];
      tick(6);
      cmp(8'(link.stretch_n), 8'(!v[0]));
    end
    str_req <= 1'b0;
    pulse_reset();
    cmp(8'(creset), 8'h1);
    tick(30);
    wait_ready();
    mode <= card_memory_mode;
    tick(30);
    wait_ready();
    pulse_reset();
    cmp(8'(creset), 8'h1);
    cmp(8'(link.wp_n), 8'h1);
    tick(30);
    wait_ready();
    wr(1'b1, 8'h80);
    cmp(8'(creset), 8'h1);
    cmp(creg, 8'h00);
    tick(30);
    wait_ready();
    // Reset both ends again with the reset pin held from power-up
    reset_n_i <= 1'b0;
    hw_reset <= 1'b1;
    tick(8);
    reset_n_i <= 1'b1;
    tick(30);
    wait_ready();
    cmp(8'(creset), 8'h0);
    hw_reset <= 1'b0;
    tick(40);
    pulse_reset();
    cmp(8'(creset), 8'h1);
    finish_test();
  end
endmodule // tb_card_host_control_pins
